// *** logic/ldcd_cfg.svh ***
`ifndef LDCD_CFG_SVH
`define LDCD_CFG_SVH

// ***************************************************
// Command edge counts
// ***************************************************
`define LDCD_CMD_LATCH    6'h01
`define LDCD_CMD_VSYNC    6'h02
`define LDCD_CMD_WR_CFG1  6'h04
`define LDCD_CMD_RD_CFG1  6'h05
`define LDCD_CMD_DETECT   6'h07
`define LDCD_CMD_WR_CFG2  6'h08
`define LDCD_CMD_RD_CFG2  6'h09
`define LDCD_CMD_SW_RST   6'h0A
`define LDCD_CMD_ALL_ON   6'h0B
`define LDCD_CMD_ALL_OFF  6'h0C
`define LDCD_CMD_WR_CFG5  6'h0D
`define LDCD_CMD_UNLOCK   6'h0E
`define LDCD_CMD_WR_CFG6  6'h0F
`define LDCD_CMD_WR_CFG3  6'h10
`define LDCD_CMD_RD_CFG3  6'h11
`define LDCD_CMD_WR_CFG4  6'h12
`define LDCD_CMD_RD_CFG4  6'h13
`define LDCD_CMD_RD_CFG5  6'h15
`define LDCD_CMD_RD_CFG6  6'h16
`define LDCD_CMD_HW_RST   6'h1E

// ***************************************************
// Reset values and limits
// ***************************************************
`define LDCD_CFG1_RST     16'h033F
`define LDCD_CFGX_RST     16'h0000
`define LDCD_LATCH_GUARD  5'h10
`define LDCD_CNT_MAX      6'h3F

`endif

// *** logic/ldcd_pkg.sv ***
package ldcd_pkg;

  // Strobe phase, one-hot
  typedef enum logic [2:0] {
    LDCD_IDLE = 3'h1,
    LDCD_HIGH = 3'h2,
    LDCD_EXEC = 3'h4
  } ldcd_phase_t;

  // Six configuration words
  typedef logic [5:0][15:0] ldcd_cfg_arr_t;

  // Whole state of the decoder
  typedef struct packed {
    ldcd_phase_t   phase;
    logic          sck_prev;
    logic [15:0]   shift;
    logic [5:0]    cnt;
    ldcd_cfg_arr_t cfg;
    logic          unlock;
    logic [4:0]    latch_cnt;
    logic          pend;
    logic [15:0]   pend_word;
    logic          frame;
    logic          detect;
    logic          force_on;
    logic          force_off;
    logic          sw_rst;
    logic          hw_rst;
  } ldcd_state_t;

endpackage : ldcd_pkg

// *** logic/ldcd_stream_if.sv ***
// Word stream with valid and ready
interface ldcd_stream_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : ldcd_stream_if

// *** logic/ldcd_pin_sync.sv ***
// Two-flop synchroniser for pin inputs
module ldcd_pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ldcd_sync_t;

  ldcd_sync_t s_q;
  ldcd_sync_t s_d;

  // Meta stage feeds only the second stage
  always_comb begin
    s_d      = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.sync;

endmodule : ldcd_pin_sync

// *** logic/ldcd_buf.sv ***
// Small FIFO between latch and channel buffers
module ldcd_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Fill and drain sides
  ldcd_stream_if.snk in_s,
  ldcd_stream_if.src out_s
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 fill;
  } ldcd_buf_t;

  ldcd_buf_t s_q;
  ldcd_buf_t s_d;
  logic      push;
  logic      pop;

  // Handshakes
  assign in_s.ready  = (32'(s_q.fill) < DEPTH); // Room left for one more word
  assign out_s.valid = (s_q.fill != '0);
  assign out_s.data  = s_q.mem[s_q.rp];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  // Pointer and fill update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_s.data;
      s_d.wp = (32'(s_q.wp) == DEPTH - 1) ? '0 : AW'(s_q.wp + 1'b1);
    end
    if (pop) begin
      s_d.rp = (32'(s_q.rp) == DEPTH - 1) ? '0 : AW'(s_q.rp + 1'b1);
    end
    if (push && !pop) begin
      s_d.fill = (AW+1)'(s_q.fill + 1'b1);
    end else if (pop && !push) begin
      s_d.fill = (AW+1)'(s_q.fill - 1'b1);
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : ldcd_buf

// *** logic/ldcd_top.sv ***
// Notes on behaviour
// - Strobe edge count picks command, runs at fall
// - One edge latches word, stops open detection
// - Two edges update the displayed frame
// - Four edges write first config register
// - Five edges shift first config out
// - Eight, sixteen, eighteen write configs two-four
// - Thirteen, fifteen write configs five, six
// - Nine, seventeen, nineteen read configs two-four
// - Twenty-one, twenty-two read configs five, six
// - Seven edges start open-LED detection
// - Ten edges reset logic, configs kept
// - Eleven edges force all outputs on
// - Twelve edges force all outputs off
// - Thirty edges assert hardware reset
// - Protected commands ignored without preceding confirm
// - Frame update refused before sixteen latches
// - Latch cancels forced on and off
// - First config resets to 033F

`include "ldcd_cfg.svh"

module ldcd_top #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Serial link pins
  input  wire logic                   shift_clock,
  input  wire logic                   serial_in,
  input  wire logic                   latch_strobe,
  output logic                        serial_out,
  // Latched words toward channel buffers
  output logic [15:0]                 word_data,
  output logic                        word_valid,
  input  wire logic                   word_ready,
  output logic                        latch_ready,
  // Configuration contents
  output ldcd_pkg::ldcd_cfg_arr_t     cfg_regs,
  // Control outputs
  output logic                        frame_update,
  output logic                        detect_on,
  output logic                        force_on,
  output logic                        force_off,
  output logic                        sw_reset,
  output logic                        hw_reset
);

  // ***************************************************
  // Declarations
  // ***************************************************
  ldcd_pkg::ldcd_state_t s_q;
  ldcd_pkg::ldcd_state_t s_d;
  logic [2:0]            pins_s;
  logic                  sck_s;
  logic                  sin_s;
  logic                  le_s;
  logic                  sck_rise;
  logic [3:0]            wr_sel;
  logic [3:0]            rd_sel;
  logic                  cmd_ok;

  ldcd_stream_if #(.WIDTH(16)) latch_s ();
  ldcd_stream_if #(.WIDTH(16)) chan_s ();

  // ***************************************************
  // Functions
  // ***************************************************

  // Reset image of the whole state
  function automatic ldcd_pkg::ldcd_state_t rst_state();
    ldcd_pkg::ldcd_state_t r;
    r.sck_prev  = 1'b0;
    r.shift     = 16'h0000;
    r.cnt       = 6'h00;
    r.unlock    = 1'b0;
    r.latch_cnt = 5'h00;
    r.pend      = 1'b0;
    r.pend_word = 16'h0000;
    r.frame     = 1'b0;
    r.detect    = 1'b0;
    r.force_on  = 1'b0;
    r.force_off = 1'b0;
    r.sw_rst    = 1'b0;
    r.hw_rst    = 1'b0;
    r.phase  = ldcd_pkg::LDCD_IDLE;
    r.cfg[0] = `LDCD_CFG1_RST;
    r.cfg[1] = `LDCD_CFGX_RST;
    r.cfg[2] = `LDCD_CFGX_RST;
    r.cfg[3] = `LDCD_CFGX_RST;
    r.cfg[4] = `LDCD_CFGX_RST;
    r.cfg[5] = `LDCD_CFGX_RST;
    return r;
  endfunction : rst_state

  // Write count to {hit, index}
  function automatic logic [3:0] wr_index(input logic [5:0] c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      `LDCD_CMD_WR_CFG1: r = 4'h8;
      `LDCD_CMD_WR_CFG2: r = 4'h9;
      `LDCD_CMD_WR_CFG3: r = 4'hA;
      `LDCD_CMD_WR_CFG4: r = 4'hB;
      `LDCD_CMD_WR_CFG5: r = 4'hC;
      `LDCD_CMD_WR_CFG6: r = 4'hD;
      default:           r = 4'h0;
    endcase
    return r;
  endfunction : wr_index

  // Read count to {hit, index}
  function automatic logic [3:0] rd_index(input logic [5:0] c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      `LDCD_CMD_RD_CFG1: r = 4'h8;
      `LDCD_CMD_RD_CFG2: r = 4'h9;
      `LDCD_CMD_RD_CFG3: r = 4'hA;
      `LDCD_CMD_RD_CFG4: r = 4'hB;
      `LDCD_CMD_RD_CFG5: r = 4'hC;
      `LDCD_CMD_RD_CFG6: r = 4'hD;
      default:           r = 4'h0;
    endcase
    return r;
  endfunction : rd_index

  // Counts that need the confirm command first
  function automatic logic is_protected(input logic [5:0] c);
    logic r;
    r = 1'b0;
    case (c)
      `LDCD_CMD_WR_CFG1: r = 1'b1;
      `LDCD_CMD_WR_CFG2: r = 1'b1;
      `LDCD_CMD_WR_CFG3: r = 1'b1;
      `LDCD_CMD_WR_CFG4: r = 1'b1;
      `LDCD_CMD_WR_CFG5: r = 1'b1;
      `LDCD_CMD_WR_CFG6: r = 1'b1;
      `LDCD_CMD_ALL_ON:  r = 1'b1;
      `LDCD_CMD_ALL_OFF: r = 1'b1;
      default:           r = 1'b0;
    endcase
    return r;
  endfunction : is_protected

  // ***************************************************
  // Pin synchronisation
  // ***************************************************

  // All three pins pass two flops
  ldcd_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .async_in ({shift_clock, serial_in, latch_strobe}),
    .sync_out (pins_s)
  );

  // Synchronised pins and shift clock rise
  assign sck_s    = pins_s[2];
  assign sin_s    = pins_s[1];
  assign le_s     = pins_s[0];
  assign sck_rise = sck_s & ~s_q.sck_prev;

  // Decode of the held strobe count
  assign wr_sel   = wr_index(s_q.cnt);
  assign rd_sel   = rd_index(s_q.cnt);

  // Protected counts act only right after confirm
  assign cmd_ok   = ~is_protected(s_q.cnt) | s_q.unlock;

  // ***************************************************
  // Latch buffer
  // ***************************************************

  // Pending latch word enters the buffer
  // A further latch while full replaces the pending word
  assign latch_s.data  = s_q.pend_word;
  assign latch_s.valid = s_q.pend;
  assign latch_ready   = latch_s.ready;

  // Two-entry buffer absorbs receiver stalls
  ldcd_buf #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_buf (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .in_s    (latch_s),
    .out_s   (chan_s)
  );

  // Buffer head drives the word outputs
  assign word_data    = chan_s.data;
  assign word_valid   = chan_s.valid;
  assign chan_s.ready = word_ready;

  // ***************************************************
  // Next state
  // ***************************************************

  // Shift, count, decode at strobe fall
  always_comb begin
    s_d          = s_q;
    s_d.sck_prev = sck_s;
    s_d.frame    = 1'b0;
    s_d.sw_rst   = 1'b0;
    s_d.hw_rst   = 1'b0;

    // Buffer took the pending word
    if (s_q.pend && latch_s.ready) begin
      s_d.pend = 1'b0;
    end

    // Shift on each clock rise
    if (sck_rise) begin
      s_d.shift = {s_q.shift[14:0], sin_s};
      if (le_s && s_q.cnt != `LDCD_CNT_MAX) begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end

    case (s_q.phase)
      ldcd_pkg::LDCD_IDLE: begin
        s_d.cnt = 6'h00;
        if (le_s) begin
          s_d.phase = ldcd_pkg::LDCD_HIGH;
          if (sck_rise) begin
            s_d.cnt = 6'h01;
          end
        end
      end
      ldcd_pkg::LDCD_HIGH: begin
        if (!le_s) begin
          s_d.phase = ldcd_pkg::LDCD_EXEC;
        end
      end
      ldcd_pkg::LDCD_EXEC: begin
        s_d.phase  = ldcd_pkg::LDCD_IDLE;
        s_d.cnt    = 6'h00;
        s_d.unlock = (s_q.cnt == `LDCD_CMD_UNLOCK);

        // Configuration writes need confirm first
        if (wr_sel[3] && cmd_ok) begin
          s_d.cfg[wr_sel[2:0]] = s_q.shift;
        end

        // Configuration reads reload the shift path
        if (rd_sel[3]) begin
          s_d.shift = s_q.cfg[rd_sel[2:0]];
        end

        case (s_q.cnt)
          `LDCD_CMD_LATCH: begin
            s_d.pend      = 1'b1;
            s_d.pend_word = s_q.shift;
            s_d.detect    = 1'b0;
            s_d.force_on  = 1'b0;
            s_d.force_off = 1'b0;
            if (s_q.latch_cnt != `LDCD_LATCH_GUARD) begin
              s_d.latch_cnt = s_q.latch_cnt + 5'h01;
            end
          end
          `LDCD_CMD_VSYNC: begin
            s_d.frame = (s_q.latch_cnt == `LDCD_LATCH_GUARD);
          end
          `LDCD_CMD_DETECT: begin
            s_d.detect = 1'b1;
          end
          `LDCD_CMD_SW_RST: begin
            s_d.shift     = 16'h0000;
            s_d.detect    = 1'b0;
            s_d.force_on  = 1'b0;
            s_d.force_off = 1'b0;
            s_d.pend      = 1'b0;
            s_d.sw_rst    = 1'b1;
          end
          `LDCD_CMD_ALL_ON: begin
            if (cmd_ok) begin
              s_d.force_on  = 1'b1;
              s_d.force_off = 1'b0;
            end
          end
          `LDCD_CMD_ALL_OFF: begin
            if (cmd_ok) begin
              s_d.force_off = 1'b1;
              s_d.force_on  = 1'b0;
            end
          end
          `LDCD_CMD_HW_RST: begin
            s_d        = rst_state();
            s_d.hw_rst = 1'b1;
          end
          default: begin
            // Other counts act only via the unlock, write and read logic
          end
        endcase
      end
      default: begin
        s_d.phase = ldcd_pkg::LDCD_IDLE;
      end
    endcase
  end

  // ***************************************************
  // State register
  // ***************************************************

  // Synchronous active-low reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= rst_state();
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************

  // Shift path MSB drives the serial pin
  assign serial_out   = s_q.shift[15];

  // Stored configuration words
  assign cfg_regs     = s_q.cfg;

  // One-cycle command pulses, from flops
  assign frame_update = s_q.frame;
  assign sw_reset     = s_q.sw_rst;
  assign hw_reset     = s_q.hw_rst;

  // Forced and detection levels, from flops
  assign detect_on    = s_q.detect;
  assign force_on     = s_q.force_on;
  assign force_off    = s_q.force_off;

endmodule : ldcd_top

// *** tb/ldcd_ctrl_model.sv ***
// Display controller driving the serial link pins
module ldcd_ctrl_model (
  // Link pins
  output logic      shift_clock,
  output logic      serial_in,
  output logic      latch_strobe,
  input  wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link pins start low; send leaves serial_in toggled after each frame
  initial begin
    shift_clock  = 1'b0;
    serial_in    = 1'b0;
    latch_strobe = 1'b0;
  end

  // One 160 ns link period; output bit sampled before the rise
  task automatic tick(input logic bit_v, input logic stb, output logic seen);
    serial_in    = bit_v;
    latch_strobe = stb;
    #80 seen     = serial_out;
    shift_clock  = 1'b1;
    #80 shift_clock = 1'b0;
  endtask : tick

  // Shift a word MSB first, strobe high over the last n rises
  task automatic send(input logic [15:0] word, input int n, output logic [15:0] got);
    int   total;
    logic seen;
    total = (n > 16) ? n : 16;
    for (int i = 0; i < total; i++) begin
      tick((total - 1 - i < 16) ? word[total-1-i] : 1'b0, i >= total - n, seen);
      if (total - 1 - i < 16) got[total-1-i] = seen;
    end
    #40 latch_strobe = 1'b0;
    #40 serial_in = ~serial_in;
    #400;
  endtask : send
endmodule : ldcd_ctrl_model

// *** tb/ldcd_top_chk.sv ***
// Port-level checks of the command decoder
module ldcd_top_chk (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  // Link pins
  input wire logic                   shift_clock,
  input wire logic                   latch_strobe,
  input wire logic                   serial_out,
  // Word side
  input wire logic [15:0]            word_data,
  input wire logic                   word_valid,
  input wire logic                   word_ready,
  input wire logic                   latch_ready,
  input wire ldcd_pkg::ldcd_cfg_arr_t cfg_regs,
  // Controls
  input wire logic                   frame_update,
  input wire logic                   detect_on,
  input wire logic                   force_on,
  input wire logic                   force_off,
  input wire logic                   sw_reset,
  input wire logic                   hw_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ***************************************************
  // Assertions
  // ***************************************************
  cfg_reset_a: assert property ($rose(rst_b) |-> cfg_regs[0] == 16'h033F && cfg_regs[5:1] == '0)
    else $error("config reset value wrong");
  hw_state_a: assert property (hw_reset |-> cfg_regs[0] == 16'h033F && !force_on && !detect_on)
    else $error("hardware reset left state");
  frame_pulse_a: assert property (frame_update |=> !frame_update)
    else $error("frame update longer than one cycle");
  sw_keep_a: assert property (sw_reset |-> cfg_regs == $past(cfg_regs) && !detect_on && !force_on && !force_off)
    else $error("software reset wrong");
  latch_clear_a: assert property ($rose(word_valid) |-> !force_on && !force_off && !detect_on)
    else $error("latch left forced state");
  fall_only_a: assert property ($changed(cfg_regs) |-> !latch_strobe && !$past(latch_strobe))
    else $error("config changed while strobe high");
  hold_word_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("stalled word lost");
  full_flag_a: assert property (!latch_ready |-> word_valid)
    else $error("buffer full while empty");
  quiet_link_a: assert property ((!shift_clock && !latch_strobe) [*8] |=> $stable(serial_out))
    else $error("serial out moved on idle link");

  // Main scenarios reached
  cover property (frame_update);
  cover property (force_off);
  cover property (!latch_ready);
  cover property (sw_reset);
endmodule : ldcd_top_chk

bind ldcd_top ldcd_top_chk u_chk (.sys_clk, .rst_b, .shift_clock, .latch_strobe, .serial_out, .word_data,
  .word_valid, .word_ready, .latch_ready, .cfg_regs, .frame_update, .detect_on, .force_on, .force_off,
  .sw_reset, .hw_reset);

// *** tb/test_led_driver_command_decoder.sv ***
// Self-checking bench of the command decoder
module test_led_driver_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk, rst_b, shift_clock, serial_in, latch_strobe, serial_out;
  logic word_valid, word_ready, latch_ready;
  logic frame_update, detect_on, force_on, force_off, sw_reset, hw_reset;
  logic [15:0] word_data, got;
  ldcd_pkg::ldcd_cfg_arr_t cfg_regs;
  int n_mismatch, samples_checked, n_frame, n_sw, n_hw, cycles;

  ldcd_top u_dut (.sys_clk, .rst_b, .shift_clock, .serial_in, .latch_strobe, .serial_out, .word_data,
    .word_valid, .word_ready, .latch_ready, .cfg_regs, .frame_update, .detect_on, .force_on, .force_off,
    .sw_reset, .hw_reset);
  ldcd_ctrl_model u_ctrl (.shift_clock, .serial_in, .latch_strobe, .serial_out);

  // Clock, pulse counters and hang guard
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (frame_update === 1'b1) n_frame++;
    if (sw_reset === 1'b1) n_sw++;
    if (hw_reset === 1'b1) n_hw++;
    if (cycles == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Reset contents, direct and read back
  task automatic t_reset();
    chk("cfg1_reset", 16'h033F, cfg_regs[0]);
    for (int i = 1; i < 6; i++) chk("cfgx_reset", 16'h0000, cfg_regs[i]);
    u_ctrl.send(16'h0000, 5, got);
    u_ctrl.send(16'h0000, 0, got);
    chk("cfg1_read", 16'h033F, got);
  endtask : t_reset

  // Frame update refused until sixteen latches; unlisted counts idle
  task automatic t_guard();
    u_ctrl.send(16'h1234, 3, got);
    u_ctrl.send(16'h1234, 6, got);
    chk("cfg_unlisted", 16'h033F, cfg_regs[0]);
    u_ctrl.send(16'h0000, 2, got);
    for (int i = 0; i < 15; i++) u_ctrl.send(16'h0F00 + 16'(i), 1, got);
    u_ctrl.send(16'h0000, 2, got);
    chk("frame_early", 16'h0000, 16'(n_frame));
    u_ctrl.send(16'h0F0F, 1, got);
    u_ctrl.send(16'h0000, 2, got);
    chk("frame_ok", 16'h0001, 16'(n_frame));
  endtask : t_guard

  // Protected writes, locked writes and reads of all six registers
  task automatic t_cfg();
    int wr [6] = '{4, 8, 16, 18, 13, 15};
    int rd [6] = '{5, 9, 17, 19, 21, 22};
    logic [15:0] v;
    for (int i = 0; i < 6; i++) begin
      v = 16'hA5C0 + 16'(i);
      u_ctrl.send(16'h0000, 14, got);
      u_ctrl.send(v, wr[i], got);
      chk("cfg_write", v, cfg_regs[i]);
      u_ctrl.send(~v, wr[i], got);
      chk("cfg_locked", v, cfg_regs[i]);
      u_ctrl.send(16'h0000, rd[i], got);
      u_ctrl.send(16'h0000, 0, got);
      chk("cfg_read", v, got);
    end
  endtask : t_cfg

  // Two-entry buffer filled with the consumer stalled, then drained
  task automatic t_buf();
    logic [15:0] w [3] = '{16'hC001, 16'h8E02, 16'h7F03};
    @(posedge sys_clk) #1 word_ready = 1'b0;
    for (int i = 0; i < 3; i++) u_ctrl.send(w[i], 1, got);
    chk("buf_full", 16'h0000, 16'(latch_ready));
    for (int i = 0; i < 3; i++) begin
      chk("buf_valid", 16'h0001, 16'(word_valid));
      chk("buf_word", w[i], word_data);
      @(posedge sys_clk) #1 word_ready = 1'b1;
      @(posedge sys_clk) #1 word_ready = 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    chk("buf_empty", 16'h0000, 16'(word_valid));
    @(posedge sys_clk) #1 word_ready = 1'b1;
  endtask : t_buf

  // Detection, forced on and off, cleared by a latch
  task automatic t_force();
    u_ctrl.send(16'h0000, 7, got);
    chk("detect_on", 16'h0001, 16'(detect_on));
    u_ctrl.send(16'h0000, 14, got);
    u_ctrl.send(16'h0000, 11, got);
    chk("force_on", 16'h0001, 16'(force_on));
    u_ctrl.send(16'h0000, 12, got);
    chk("off_locked", 16'h0000, 16'(force_off));
    u_ctrl.send(16'h0000, 14, got);
    u_ctrl.send(16'h0000, 12, got);
    chk("force_off", 16'h0001, 16'(force_off));
    u_ctrl.send(16'h5555, 1, got);
    chk("latch_clear", 16'h0000, 16'({force_on, force_off, detect_on}));
  endtask : t_force

  // Software reset keeps configuration, hardware reset restores it
  task automatic t_rst();
    u_ctrl.send(16'h0000, 7, got);
    u_ctrl.send(16'h0000, 10, got);
    chk("sw_pulse", 16'h0001, 16'(n_sw));
    chk("sw_detect", 16'h0000, 16'(detect_on));
    chk("sw_cfg5", 16'hA5C4, cfg_regs[4]);
    u_ctrl.send(16'h0000, 30, got);
    chk("hw_pulse", 16'h0001, 16'(n_hw));
    chk("hw_cfg1", 16'h033F, cfg_regs[0]);
    chk("hw_cfg5", 16'h0000, cfg_regs[4]);
  endtask : t_rst

  // Main sequence
  initial begin
    rst_b      = 1'b0;
    word_ready = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_reset();
    t_guard();
    t_cfg();
    t_buf();
    t_force();
    t_rst();
    report_and_stop();
  end
endmodule : test_led_driver_command_decoder
